// File: rtl/osdf_formatter.sv
// on-screen character formatter with apb register access
//
// Register access over APB and the register offsets were left to the implementer.
`timescale 1ns/1ps
// How it works
// RULE1: two lines of fifteen columns at most
// RULE2: sixty-four 6x9 glyphs with rounding
// RULE3: four heights, chosen per line
// RULE4: origin steps: two clocks, four lines
// RULE5: word gap in 64 steps
// RULE6: line gap 4 to 252 lines
// RULE7: none, box or fringe backdrop per word
// RULE8: master enable off hides everything; the screen blanking bit vspace_r[6] still drives pix_blank
// RULE9: first entry per line is format only
// RULE10: bit 6 marks space, else glyph code
// RULE11: smallest dot is two lines, two clocks
// RULE12: glyphs abut with no gap
// RULE13: size bit with global size bits
// RULE14: line gap only when enabled
// RULE15: word gap adds register to space
// RULE16: three colour bits pick colour
// RULE17: backdrop select picks set 0 or 1
// RULE18: word shows if its enable and master
// RULE19: only two emulator lines rendered
// RULE20: software fills spare formats, set 1 clear
// RULE21: only master enable writable while on
// RULE22: size bits map to 18H..72H
// RULE23: sync counters locate dot, drive blanking
module osdf_formatter (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [12:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              hsync_i,
  input  wire logic              vsync_i,
  output osdf_pkg::osdf_rgb_t    pix_colour,
  output logic                   pix_blank
);

  // ==========================================================
  // storage and control registers
  logic [7:0]                  ram_r   [0:31];
  logic [5:0]                  glyph_r [0:1023];
  logic [6:0]                  vstart_r;
  logic [6:0]                  hstart_r;
  logic [6:0]                  vspace_r;
  logic [7:0]                  hspace_r;
  logic [7:0]                  bkctl_r;
  logic                        master_en_r;
  logic [31:0]                 prdata_r;
  logic                        perr_r;
  logic [31:0]                 rd_nxt;
  logic                        err_nxt;
  logic                        wr_ok;
  logic                        hit_ram;
  logic                        hit_glyph;
  logic [31:0]                 status_w;

  // ==========================================================
  // apb decode, answered in the setup cycle
  assign hit_glyph = paddr[12];
  assign hit_ram   = (paddr[12:7] == 6'h00);

  always_comb begin
    rd_nxt  = 32'h0;
    err_nxt = 1'b0;
    if (paddr[1:0] != 2'h0) begin
      err_nxt = 1'b1;
    end else if (hit_glyph) begin
      // RULE21: locked while shown
      if (master_en_r) begin
        err_nxt = 1'b1;
      end else begin
        rd_nxt = {26'h0, glyph_r[paddr[11:2]]};
      end
    end else if (hit_ram) begin
      if (master_en_r) begin
        err_nxt = 1'b1;
      end else begin
        rd_nxt = {24'h0, ram_r[paddr[6:2]]};
      end
    end else begin
      case (paddr)
        osdf_pkg::OFS_VSTART: begin
          err_nxt = master_en_r;
          rd_nxt  = master_en_r ? 32'h0 : {25'h0, vstart_r};
        end
        osdf_pkg::OFS_HSTART: begin
          err_nxt = master_en_r;
          rd_nxt  = master_en_r ? 32'h0 : {25'h0, hstart_r};
        end
        osdf_pkg::OFS_VSPACE: begin
          err_nxt = master_en_r;
          rd_nxt  = master_en_r ? 32'h0 : {25'h0, vspace_r};
        end
        osdf_pkg::OFS_HSPACE: begin
          err_nxt = master_en_r;
          rd_nxt  = master_en_r ? 32'h0 : {24'h0, hspace_r};
        end
        osdf_pkg::OFS_BKCTL: begin
          err_nxt = master_en_r;
          rd_nxt  = master_en_r ? 32'h0 : {24'h0, bkctl_r};
        end
        // write-only; reads give zero
        osdf_pkg::OFS_MASTER: begin
          rd_nxt = 32'h0;
        end
        osdf_pkg::OFS_STATUS: begin
          err_nxt = pwrite;
          rd_nxt  = status_w;
        end
        default: begin
          err_nxt = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0;
      perr_r   <= 1'b0;
    end else if (psel && !penable) begin
      prdata_r <= pwrite ? 32'h0 : rd_nxt;
      perr_r   <= err_nxt;
    end
  end

  // zero wait states: data already in flops at the access cycle
  assign pready  = 1'b1;
  assign pslverr = psel & penable & perr_r;
  assign prdata  = prdata_r;
  assign wr_ok   = psel & penable & pwrite & ~perr_r;

  // ==========================================================
  // display ram and glyph memory, no reset (pure data)
  always_ff @(posedge pclk) begin
    if (wr_ok && hit_ram) begin
      ram_r[paddr[6:2]] <= pwdata[7:0];
    end
  end

  // RULE2: loadable 64 x 9 glyph set
  always_ff @(posedge pclk) begin
    if (wr_ok && hit_glyph) begin
      glyph_r[paddr[11:2]] <= pwdata[5:0];
    end
  end

  // ==========================================================
  // control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vstart_r    <= osdf_pkg::RST_CTRL7;
      hstart_r    <= osdf_pkg::RST_CTRL7;
      vspace_r    <= osdf_pkg::RST_CTRL7;
      hspace_r    <= osdf_pkg::RST_CTRL8;
      bkctl_r     <= osdf_pkg::RST_CTRL8;
      master_en_r <= osdf_pkg::RST_MASTER;
    end else if (wr_ok && !hit_glyph && !hit_ram) begin
      // RULE21: master enable always writable
      case (paddr)
        osdf_pkg::OFS_VSTART: vstart_r    <= pwdata[6:0];
        osdf_pkg::OFS_HSTART: hstart_r    <= pwdata[6:0];
        osdf_pkg::OFS_VSPACE: vspace_r    <= pwdata[6:0];
        osdf_pkg::OFS_HSPACE: hspace_r    <= pwdata[7:0];
        osdf_pkg::OFS_BKCTL:  bkctl_r     <= pwdata[7:0];
        osdf_pkg::OFS_MASTER: master_en_r <= pwdata[0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // sync pins
  logic hs_s;
  logic vs_s;
  logic hs_d_r;
  logic vs_d_r;
  logic hs_rise_d_r;
  logic hs_rise;
  logic vs_rise;

  osdf_sync2 u_hs_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .d     (hsync_i),
    .q     (hs_s)
  );

  osdf_sync2 u_vs_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .d     (vsync_i),
    .q     (vs_s)
  );

  assign hs_rise = hs_s & ~hs_d_r;
  assign vs_rise = vs_s & ~vs_d_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hs_d_r      <= 1'b0;
      vs_d_r      <= 1'b0;
      hs_rise_d_r <= 1'b0;
    end else begin
      hs_d_r      <= hs_s;
      vs_d_r      <= vs_s;
      hs_rise_d_r <= hs_rise;
    end
  end

  // ==========================================================
  // per-line format and size
  osdf_pkg::osdf_vstate_t   vstate_r;
  osdf_pkg::osdf_line_fmt_t fmt0;
  osdf_pkg::osdf_line_fmt_t fmt1;
  osdf_pkg::osdf_line_fmt_t fmt_cur;
  logic                     line_r;
  logic [7:0]               vcnt_r;
  logic [2:0]               vsub_r;
  logic [3:0]               row_r;
  logic [2:0]               k0;
  logic [2:0]               k1;
  logic [2:0]               kx;
  logic [3:0]               span_m1;

  // RULE9: entry 0 of each line is its format
  assign fmt0    = osdf_pkg::osdf_line_fmt_t'(ram_r[5'h00]);
  assign fmt1    = osdf_pkg::osdf_line_fmt_t'(ram_r[5'h10]);
  assign fmt_cur = line_r ? fmt1 : fmt0;
  // RULE13: per-line size from line bit and globals
  // RULE22: mapping held in the size function
  assign k0 = osdf_pkg::osdf_size_mult(hspace_r[7], hspace_r[6], fmt0.size);
  assign k1 = osdf_pkg::osdf_size_mult(hspace_r[7], hspace_r[6], fmt1.size);
  // RULE3: two sizes per screen, one per line
  assign kx = line_r ? k1 : k0;
  // RULE11: a dot spans 2k lines and 2k clocks
  assign span_m1 = {kx, 1'b0} - 4'h1;

  // ==========================================================
  // vertical walk, stepped by hsync
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vstate_r <= osdf_pkg::V_DONE;
      line_r   <= 1'b0;
      vcnt_r   <= 8'h00;
      vsub_r   <= 3'h0;
      row_r    <= 4'h0;
    end else if (vs_rise) begin
      vstate_r <= osdf_pkg::V_WAIT;
      line_r   <= 1'b0;
      vcnt_r   <= 8'h00;
    end else if (hs_rise) begin
      case (vstate_r)
        // RULE4: origin in steps of four lines
        osdf_pkg::V_WAIT: begin
          if (vcnt_r >= {vstart_r[5:0], 2'h0}) begin
            vstate_r <= osdf_pkg::V_GLYPH;
            vsub_r   <= 3'h0;
            row_r    <= 4'h0;
          end else begin
            vcnt_r <= vcnt_r + 8'h01;
          end
        end
        osdf_pkg::V_GLYPH: begin
          if ({1'b0, vsub_r} == span_m1) begin
            vsub_r <= 3'h0;
            if (row_r == osdf_pkg::LAST_ROW) begin
              row_r <= 4'h0;
              // RULE1: stop after the second line
              // RULE19: device keeps just two lines
              if (line_r) begin
                vstate_r <= osdf_pkg::V_DONE;
              // RULE14: gap only with line gap enable
              end else if (fmt_cur.line_gap_enable && vspace_r[5:0] != 6'h00) begin
                vstate_r <= osdf_pkg::V_GAP;
                vcnt_r   <= 8'h01;
                line_r   <= 1'b1;
              end else begin
                line_r <= 1'b1;
              end
            end else begin
              row_r <= row_r + 4'h1;
            end
          end else begin
            vsub_r <= vsub_r + 3'h1;
          end
        end
        // RULE6: gap of 4 x register lines
        osdf_pkg::V_GAP: begin
          if (vcnt_r >= {vspace_r[5:0], 2'h0}) begin
            vstate_r <= osdf_pkg::V_GLYPH;
            vsub_r   <= 3'h0;
            row_r    <= 4'h0;
          end else begin
            vcnt_r <= vcnt_r + 8'h01;
          end
        end
        osdf_pkg::V_DONE: ;
        default: vstate_r <= osdf_pkg::V_DONE;
      endcase
    end
  end

  // ==========================================================
  // horizontal walk along the line entries
  osdf_pkg::osdf_hstate_t    hstate_r;
  osdf_pkg::osdf_word_attr_t ent;
  osdf_pkg::osdf_rgb_t       colour_r;
  logic                      bgs_r;
  logic                      show_r;
  logic [7:0]                hcnt_r;
  logic [3:0]                ptr_r;
  logic [2:0]                hsub_r;
  logic [6:0]                dot_r;
  logic [6:0]                dot_lim;
  logic [7:0]                lead_m1;

  assign ent = osdf_pkg::osdf_word_attr_t'(ram_r[{line_r, ptr_r}]);
  // RULE4: origin in steps of two clocks plus fetch bias
  assign lead_m1 = {7'({2'h0, hstart_r[5:0]} + osdf_pkg::HSTART_BIAS), 1'b0} - 8'h01;
  // RULE5: register sets extra word gap
  // RULE15: space is 6 dots, plus 1+register when enabled
  assign dot_lim = (ent.is_space && ent.word_gap_enable) ?
                   (osdf_pkg::WORD_GAP_BIAS + {1'b0, hspace_r[5:0]}) : osdf_pkg::SPACE_DOTS;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hstate_r <= osdf_pkg::H_IDLE;
      hcnt_r   <= 8'h00;
      ptr_r    <= 4'h0;
      hsub_r   <= 3'h0;
      dot_r    <= 7'h00;
      colour_r <= '0;
      bgs_r    <= 1'b0;
      show_r   <= 1'b0;
    end else if (hs_rise_d_r) begin
      hstate_r <= (vstate_r == osdf_pkg::V_GLYPH) ? osdf_pkg::H_LEAD : osdf_pkg::H_IDLE;
      hcnt_r   <= 8'h00;
    end else begin
      case (hstate_r)
        osdf_pkg::H_LEAD: begin
          if (hcnt_r == lead_m1) begin
            // RULE9: skip format entry, take its attributes
            hstate_r <= osdf_pkg::H_CELL;
            ptr_r    <= 4'h1;
            hsub_r   <= 3'h0;
            dot_r    <= 7'h00;
            colour_r <= fmt_cur.colour;
            bgs_r    <= fmt_cur.backdrop_select;
            show_r   <= fmt_cur.word_show;
          end else begin
            hcnt_r <= hcnt_r + 8'h01;
          end
        end
        // RULE12: next cell starts on the very next clock
        osdf_pkg::H_CELL: begin
          if ({1'b0, hsub_r} == span_m1) begin
            hsub_r <= 3'h0;
            if (dot_r == dot_lim - 7'h01) begin
              dot_r <= 7'h00;
              // RULE16: space sets next word colour
              // RULE17: and its backdrop set
              if (ent.is_space) begin
                colour_r <= ent.colour;
                bgs_r    <= ent.backdrop_select;
                show_r   <= ent.word_show;
              end
              // RULE1: fifteen columns after the format entry
              if (ptr_r == osdf_pkg::LAST_COL_PTR) begin
                hstate_r <= osdf_pkg::H_IDLE;
              end else begin
                ptr_r <= ptr_r + 4'h1;
              end
            end else begin
              dot_r <= dot_r + 7'h01;
            end
          end else begin
            hsub_r <= hsub_r + 3'h1;
          end
        end
        osdf_pkg::H_IDLE: ;
        default: hstate_r <= osdf_pkg::H_IDLE;
      endcase
    end
  end

  // ==========================================================
  // dot decode with rounding and fringe
  osdf_pkg::osdf_backdrop_t bk;
  logic [9:0]               gaddr;
  logic [7:0]               cw;
  logic [7:0]               pw;
  logic [7:0]               nw;
  logic [2:0]               c;
  logic                     upper;
  logic                     lit;
  logic                     round_px;
  logic                     glyph_px;
  logic                     fringe_px;
  logic                     bg_px;
  logic                     visible;

  // RULE10: bit 6 marks a space, low six bits a glyph
  assign gaddr = {ent[5:0], row_r};
  assign cw    = {1'b0, glyph_r[gaddr], 1'b0};
  assign pw    = (row_r == 4'h0) ? 8'h00 : {1'b0, glyph_r[gaddr - 10'h001], 1'b0};
  assign nw    = (row_r == osdf_pkg::LAST_ROW) ? 8'h00 : {1'b0, glyph_r[gaddr + 10'h001], 1'b0};
  assign c     = 3'h6 - dot_r[2:0];
  assign upper = ({1'b0, vsub_r} < {1'b0, kx});
  assign lit   = cw[c];

  // RULE2: half-dot fill on diagonals smooths edges
  assign round_px = ~lit & (upper ?
                    (pw[c] & ((cw[c + 3'h1] & ~pw[c + 3'h1]) | (cw[c - 3'h1] & ~pw[c - 3'h1]))) :
                    (nw[c] & ((cw[c + 3'h1] & ~nw[c + 3'h1]) | (cw[c - 3'h1] & ~nw[c - 3'h1]))));
  assign glyph_px  = ~ent.is_space & (lit | round_px);
  assign fringe_px = ~ent.is_space & ~glyph_px & (cw[c + 3'h1] | cw[c - 3'h1] | pw[c] | nw[c]);

  // RULE17: set 1 upper nibble, set 0 lower
  // RULE20: set 1 left transparent by software
  assign bk = bgs_r ? osdf_pkg::osdf_backdrop_t'(bkctl_r[7:4]) : osdf_pkg::osdf_backdrop_t'(bkctl_r[3:0]);
  // RULE7: fringe outline, else box; spaces follow blanking disable
  assign bg_px = bk.backdrop_enable &
                 (vstart_r[6] ? fringe_px : (~ent.is_space | ~hstart_r[6]));

  // RULE8: master enable gates glyphs and backdrops, not the vspace_r[6] screen blanking
  // RULE18: word needs its own enable too
  assign visible = master_en_r & show_r & (hstate_r == osdf_pkg::H_CELL) &
                   (vstate_r == osdf_pkg::V_GLYPH);

  // ==========================================================
  // pixel outputs, one clock behind the walk
  // RULE23: blank while glyph or backdrop drawn
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pix_colour <= '0;
      pix_blank  <= 1'b0;
    end else begin
      if (visible && glyph_px) begin
        pix_colour <= colour_r;
      end else if (visible && bg_px) begin
        pix_colour <= bk.colour;
      end else begin
        pix_colour <= '0;
      end
      // screen blanking bit forces blank even when disabled
      pix_blank <= vspace_r[6] | (visible & (glyph_px | bg_px));
    end
  end

  // ==========================================================
  // status word
  assign status_w = {24'h0, vstate_r, hstate_r, line_r, 2'h0, master_en_r};

endmodule

// File: shared/osdf_pkg.sv
// constants, layouts and states shared by the display formatter
package osdf_pkg;

  // ==========================================================
  // bus map (byte addresses)
  localparam int          ADDR_W         = 13;
  localparam logic [12:0] OFS_RAM_BASE   = 13'h0000;
  localparam logic [12:0] OFS_VSTART     = 13'h0080;
  localparam logic [12:0] OFS_HSTART     = 13'h0084;
  localparam logic [12:0] OFS_VSPACE     = 13'h0088;
  localparam logic [12:0] OFS_HSPACE     = 13'h008c;
  localparam logic [12:0] OFS_BKCTL      = 13'h0090;
  localparam logic [12:0] OFS_MASTER     = 13'h0094;
  localparam logic [12:0] OFS_STATUS     = 13'h0098;
  localparam logic [12:0] OFS_GLYPH_BASE = 13'h1000;

  // ==========================================================
  // reset values
  localparam logic [6:0]  RST_CTRL7      = 7'h00;
  localparam logic [7:0]  RST_CTRL8      = 8'h00;
  localparam logic        RST_MASTER     = 1'b0;

  // ==========================================================
  // geometry and timing counts
  localparam int          LINES          = 2;
  localparam int          COLS           = 15;
  localparam int          GLYPHS         = 64;
  localparam int          GLYPH_ROWS     = 9;
  localparam int          GLYPH_COLS     = 6;
  localparam logic [3:0]  LAST_ROW       = 4'h8;
  localparam logic [3:0]  LAST_COL_PTR   = 4'hf;
  localparam logic [2:0]  LAST_DOT       = 3'h5;
  localparam logic [6:0]  SPACE_DOTS     = 7'h06;
  localparam logic [7:0]  HSTART_BIAS    = 8'h0a;
  localparam logic [6:0]  WORD_GAP_BIAS  = 7'h07;

  // ==========================================================
  // field layouts
  typedef struct packed {
    logic red;
    logic green;
    logic blue;
  } osdf_rgb_t;

  typedef struct packed {
    logic      unused;
    logic      size;
    logic      backdrop_select;
    logic      word_show;
    osdf_rgb_t colour;
    logic      line_gap_enable;
  } osdf_line_fmt_t;

  typedef struct packed {
    logic      unused;
    logic      is_space;
    osdf_rgb_t colour;
    logic      backdrop_select;
    logic      word_show;
    logic      word_gap_enable;
  } osdf_word_attr_t;

  typedef struct packed {
    logic      backdrop_enable;
    osdf_rgb_t colour;
  } osdf_backdrop_t;

  // ==========================================================
  // state machines
  typedef enum logic [1:0] {V_WAIT, V_GLYPH, V_GAP, V_DONE} osdf_vstate_t;
  typedef enum logic [1:0] {H_IDLE, H_LEAD, H_CELL} osdf_hstate_t;

  // ==========================================================
  // size bits to dot multiplier (1..4)
  function automatic logic [2:0] osdf_size_mult(input logic gsh, input logic gsl, input logic s);
    case ({gsh, gsl, s})
      3'h0, 3'h2:      return 3'h1;
      3'h1, 3'h4, 3'h6: return 3'h2;
      3'h3, 3'h5:      return 3'h3;
      default:         return 3'h4;
    endcase
  endfunction

endpackage

// File: rtl/osdf_sync2.sv
// two-flop synchroniser for one pin
`timescale 1ns/1ps
module osdf_sync2 (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic d,
  output logic      q
);

  logic meta_r;

  // ==========================================================
  // first stage feeds only the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= 1'b0;
      q      <= 1'b0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule

// File: tb/osdf_formatter_assertions.sv
// port-level checker for the display formatter
`timescale 1ns/1ps
module osdf_formatter_assertions (
  input wire logic                 pclk,
  input wire logic                 presetn,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [12:0]          paddr,
  input wire logic [31:0]          pwdata,
  input wire logic [31:0]          prdata,
  input wire logic                 pready,
  input wire logic                 pslverr,
  input wire logic                 hsync_i,
  input wire logic                 vsync_i,
  input wire osdf_pkg::osdf_rgb_t  pix_colour,
  input wire logic                 pix_blank
);
  // ==========
  // helper state
  logic       on_q;
  logic [2:0] off_cnt;
  wire        acc = psel && penable;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) on_q <= 1'b0;
    else if (acc && pready && pwrite && paddr == 13'h094) on_q <= pwdata[0];
  end
  // pipeline may still hold dots, so wait a few clocks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) off_cnt <= 3'h0;
    else if (on_q) off_cnt <= 3'h0;
    else if (off_cnt != 3'h7) off_cnt <= off_cnt + 3'h1;
  end
  // ==========
  // assertions
  AST_ERR_IN_ACCESS: assert property (pslverr |-> acc)
    else $error("error flag outside access");
  AST_READY_HIGH: assert property (acc |-> pready)
    else $error("no ready in access");
  AST_MISALIGN_ERR: assert property (acc && paddr[1:0] != 2'h0 |-> pslverr)
    else $error("misaligned access accepted");
  AST_UNMAPPED_ERR: assert property (acc && paddr > 13'h098 && paddr < 13'h1000 |-> pslverr)
    else $error("unmapped access accepted");
  AST_STATUS_RO: assert property (acc && pwrite && paddr == 13'h098 |-> pslverr)
    else $error("status write accepted");
  AST_LOCKED_ERR: assert property (acc && on_q && paddr <= 13'h090 |-> pslverr)
    else $error("locked place reachable");
  AST_MASTER_OPEN: assert property (acc && paddr == 13'h094 |-> !pslverr && (pwrite || prdata == 32'h0))
    else $error("master enable access wrong");
  AST_ERR_READ_ZERO: assert property (acc && !pwrite && pslverr |-> prdata == 32'h0)
    else $error("refused read not zero");
  AST_COLOUR_BLANK: assert property (pix_colour != 3'h0 |-> pix_blank)
    else $error("colour without blanking");
  AST_DARK_OFF: assert property (off_cnt == 3'h7 |-> pix_colour == 3'h0)
    else $error("colour while display off");
  cover property (acc && pslverr);
  cover property (pix_blank && pix_colour == 3'h7);
  cover property (acc && pwrite && paddr == 13'h094 && pwdata[0]);
endmodule
bind osdf_formatter osdf_formatter_assertions CHK (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .hsync_i(hsync_i), .vsync_i(vsync_i),
  .pix_colour(pix_colour), .pix_blank(pix_blank));

// File: tb/osdf_video_sink.sv
// video path model: sync source and pixel observer
`timescale 1ns/1ps
module osdf_video_sink (
  input  wire logic                pclk,
  input  wire osdf_pkg::osdf_rgb_t pix_colour,
  input  wire logic                pix_blank,
  output logic                     hsync_i,
  output logic                     vsync_i
);
  int                  lit;
  osdf_pkg::osdf_rgb_t seen;
  logic                on;
  initial begin
    hsync_i = 1'b0;
    vsync_i = 1'b0;
    on = 1'b0;
  end
  always @(posedge pclk) begin
    if (on && pix_blank === 1'b1) begin
      lit <= lit + 1;
      seen <= seen | pix_colour;
    end
  end
  task automatic run_frame(input int lines);
    lit = 0;
    seen = 3'h0;
    on = 1'b1;
    @(posedge pclk);
    vsync_i <= 1'b1;
    repeat (4) @(posedge pclk);
    vsync_i <= 1'b0;
    repeat (lines) begin
      repeat (20) @(posedge pclk);
      hsync_i <= 1'b1;
      repeat (4) @(posedge pclk);
      hsync_i <= 1'b0;
      repeat (96) @(posedge pclk);
    end
    on = 1'b0;
  endtask
endmodule

// File: tb/osdf_formatter_tb_top.sv
// self-checking bench for the display formatter
`timescale 1ns/1ps
module osdf_formatter_tb_top;
  logic                pclk, presetn, psel, penable, pwrite, pready, pslverr, hsync_i, vsync_i, pix_blank;
  logic [12:0]         paddr;
  logic [31:0]         pwdata, prdata;
  logic [32:0]         r;
  osdf_pkg::osdf_rgb_t pix_colour;
  int                  errors, check_count;
  osdf_formatter DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .hsync_i(hsync_i), .vsync_i(vsync_i), .pix_colour(pix_colour), .pix_blank(pix_blank));
  osdf_video_sink SNK (.pclk(pclk), .pix_colour(pix_colour), .pix_blank(pix_blank),
    .hsync_i(hsync_i), .vsync_i(vsync_i));
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // ==========
  // shared tasks
  task automatic check(input logic [32:0] got, input logic [32:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [12:0] a, input logic [31:0] d, output logic [32:0] re);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    re = {pslverr, prdata};
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [12:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, r);
  endtask
  task automatic stop_test();
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // ==========
  // scenarios
  task automatic t_regs();
    wr(13'h080, 32'h21);
    xfer(1'b0, 13'h080, 32'h0, r);
    check(r, {1'b0, 32'h21});
    wr(13'h08c, 32'hff);
    xfer(1'b0, 13'h08c, 32'h0, r);
    check(r, {1'b0, 32'hff});
    wr(13'h088, 32'h3f);
    xfer(1'b0, 13'h088, 32'h0, r);
    check(r, {1'b0, 32'h3f});
    xfer(1'b0, 13'h094, 32'h0, r);
    check(r, 33'h0);
    xfer(1'b0, 13'h09c, 32'h0, r);
    check(r, {1'b1, 32'h0});
    xfer(1'b1, 13'h081, 32'h1, r);
    check({32'h0, r[32]}, 33'h1);
    xfer(1'b1, 13'h098, 32'h1, r);
    check({32'h0, r[32]}, 33'h1);
  endtask
  task automatic t_lock();
    wr(13'h094, 32'h1);
    xfer(1'b1, 13'h080, 32'h05, r);
    check({32'h0, r[32]}, 33'h1);
    xfer(1'b0, 13'h004, 32'h0, r);
    check(r, {1'b1, 32'h0});
    wr(13'h094, 32'h0);
    xfer(1'b0, 13'h080, 32'h0, r);
    check(r, {1'b0, 32'h21});
  endtask
  task automatic frame(input logic [2:0] c, input logic sh, input logic ms, input logic [1:0] gs,
                       input logic s, input int k, input logic [3:0] bk);
    int lit_exp;
    wr(13'h094, 32'h0);
    wr(13'h080, 32'h01);
    wr(13'h084, 32'h00);
    wr(13'h088, 32'h00);
    wr(13'h08c, {24'h0, gs, 6'h0});
    wr(13'h090, {28'h0, bk});
    for (int e = 0; e < 32; e++)
      wr(13'(e * 4), e == 0 ? {25'h0, s, 1'b0, sh, c, 1'b0} : e == 1 ? 32'h01 : e == 16 ? 32'h0 : 32'h40);
    wr(13'h094, {31'h0, ms});
    SNK.run_frame(44);
    // box backdrop adds the space cell after the glyph
    lit_exp = (sh && ms) ? (bk[3] ? 432 : 216) * k * k : 0;
    check(33'(SNK.lit), 33'(lit_exp));
    check({30'h0, SNK.seen}, (sh && ms) ? {30'h0, c | (bk[3] ? bk[2:0] : 3'h0)} : 33'h0);
  endtask
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 13'h0;
    pwdata = 32'h0;
    errors = 0;
    check_count = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_lock();
    // codes 0 and 1 fully lit, so a misread space shows
    for (int i = 0; i < 32; i++)
      wr(13'(13'h1000 + i * 4), (i % 16 < 9) ? 32'h3f : 32'h0);
    for (int c = 0; c < 8; c++)
      frame(3'(c), 1'b1, 1'b1, 2'b01, 1'b0, 1, 4'h0);
    frame(3'h7, 1'b0, 1'b1, 2'b00, 1'b0, 1, 4'h0);
    frame(3'h6, 1'b1, 1'b0, 2'b00, 1'b0, 1, 4'h0);
    frame(3'h5, 1'b1, 1'b1, 2'b10, 1'b0, 2, 4'h0);
    frame(3'h3, 1'b1, 1'b1, 2'b00, 1'b1, 2, 4'h0);
    frame(3'h1, 1'b1, 1'b1, 2'b00, 1'b0, 1, 4'hc);
    stop_test();
  end
  initial begin
    repeat (90000) @(posedge pclk);
    errors++;
    stop_test();
  end
endmodule
